// ---- src/cfs_defs.svh ----
// register offsets, bit positions, reset values and limits of the fault status bank
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH
`define CFS_ADDR_ADC_LO 8'h1E
`define CFS_ADDR_ADC_HI 8'h1F
`define CFS_ADDR_STATUS 8'h20
`define CFS_BIT_IN_OV 7
`define CFS_BIT_DIS_OC 6
`define CFS_BIT_IN_OC 5
`define CFS_BIT_SYS_OV 4
`define CFS_BIT_SYS_UV 3
`define CFS_BIT_FORCED_OFF 2
`define CFS_BIT_REV_OV 1
`define CFS_BIT_REV_UV 0
`define CFS_READ_CLEAR_MASK 8'hE7
`define CFS_WRITE_CLEAR_MASK 8'h18
`define CFS_STATUS_RESET 8'h00
`define CFS_ADC_RESET 16'h0000
`define CFS_ADC_MAX 16'h1FFF
`define CFS_SYNC_STAGES 3
`endif

// ---- src/cfs_pkg.sv ----
// shared types of the fault status bank
package cfs_pkg;
  typedef logic [7:0] cfs_byte_t;
  typedef logic [15:0] cfs_reading_t;
endpackage

// ---- src/cfs_fault_status.sv ----
// fault status byte and comparator input reading with host register access
//
// How it works
// - the 16-bit comparator input reading is read as low byte at 0x1E and high byte at 0x1F.
// - the reading has 1 mV per code and conversion results above 0x1FFF are held at 0x1FFF.
// - after reset or register reset the reading is zero until a new result is loaded.
// - read-cleared fault bits set when their fault occurs and stay set at least until a read.
// - a read-cleared bit whose fault is still present at the read stays one.
// - once read, a set read-cleared bit clears itself as soon as its fault goes away.
// - a system overvoltage sets bit 4 and the converter stays off while it is high.
// - bit 4 is cleared by the host writing zero to it or by removal of the adapter.
// - a system undervoltage latches bit 3 until cleared, converter off while it is high.
// - bit 3 is cleared by a host write of zero or by adapter removal, letting the converter run.
// - a low comparator pin forces the converter off and sets read-cleared bit 2.
// - bits 7,6,5 are input overvoltage, discharge and input overcurrent; 1,0 reverse OV/UV.
// - the status byte at 0x20 resets to zero and a register reset clears it.
`timescale 1ns/100ps
`include "cfs_defs.svh"
module cfs_fault_status #(
  parameter int ADC_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_reg_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire cfs_pkg::cfs_byte_t i_reg_wdata,
  output cfs_pkg::cfs_byte_t o_reg_rdata,
  input wire logic [ADC_W-1:0] i_adc_code,
  input wire logic i_adc_valid,
  input wire logic i_input_overvoltage_fault,
  input wire logic i_battery_discharge_overcurrent_fault,
  input wire logic i_input_overcurrent_fault,
  input wire logic i_system_overvoltage,
  input wire logic i_system_undervoltage,
  input wire logic i_reverse_output_overvoltage_fault,
  input wire logic i_reverse_output_undervoltage_fault,
  input wire logic i_comparator_input_pin_n,
  input wire logic i_adapter_present,
  output logic o_converter_off
);
  import cfs_pkg::*;

  function automatic cfs_reading_t clamp_code(input logic [ADC_W-1:0] code);
    if (code > ADC_W'(`CFS_ADC_MAX)) begin
      clamp_code = `CFS_ADC_MAX;
    end else begin
      clamp_code = 16'(code);
    end
  endfunction

  // status address decode
  function automatic logic is_status(input logic [7:0] addr);
    is_status = (addr == `CFS_ADDR_STATUS);
  endfunction

  logic [`CFS_SYNC_STAGES-1:0] cmp_sync;
  logic [`CFS_SYNC_STAGES-1:0] next_cmp_sync;
  logic cmp_n;
  logic next_cmp_n;
  cfs_byte_t status;
  cfs_byte_t next_status;
  cfs_byte_t armed;
  cfs_byte_t next_armed;
  cfs_reading_t adc;
  cfs_reading_t next_adc;
  cfs_byte_t next_rdata;
  logic next_conv_off;
  cfs_byte_t fault;
  cfs_byte_t wclr;
  cfs_byte_t disarm;
  logic rd_status;
  logic wr_status;

  // comparator pin filter: change taken when stages 2 and 3 agree
  always_comb begin
    next_cmp_sync = {cmp_sync[`CFS_SYNC_STAGES-2:0], i_comparator_input_pin_n};
    next_cmp_n = cmp_n;
    if (cmp_sync[1] == cmp_sync[2]) begin
      next_cmp_n = cmp_sync[2];
    end
  end

  always_comb begin
    rd_status = i_reg_rd && is_status(i_reg_addr);
    wr_status = i_reg_wr && is_status(i_reg_addr);
    fault = '0;
    fault[`CFS_BIT_IN_OV] = i_input_overvoltage_fault;
    fault[`CFS_BIT_DIS_OC] = i_battery_discharge_overcurrent_fault;
    fault[`CFS_BIT_IN_OC] = i_input_overcurrent_fault;
    fault[`CFS_BIT_SYS_OV] = i_system_overvoltage;
    fault[`CFS_BIT_SYS_UV] = i_system_undervoltage;
    fault[`CFS_BIT_FORCED_OFF] = ~cmp_n;
    fault[`CFS_BIT_REV_OV] = i_reverse_output_overvoltage_fault;
    fault[`CFS_BIT_REV_UV] = i_reverse_output_undervoltage_fault;
    // write of zero or unplug clears bits 4 and 3
    wclr = ({8{wr_status}} & ~i_reg_wdata) | {8{~i_adapter_present}};
    wclr = wclr & `CFS_WRITE_CLEAR_MASK;
    // read-cleared bits: a read arms, writes never touch them
    disarm = (armed | (rd_status ? status : 8'h00)) & `CFS_READ_CLEAR_MASK;
    // set wins over read, write and unplug clears; a register reset wins over set
    next_status = fault | (status & ~disarm & ~wclr);
    next_armed = (armed | (rd_status ? status : 8'h00)) & next_status & `CFS_READ_CLEAR_MASK;
    next_adc = adc;
    if (i_adc_valid) begin
      next_adc = clamp_code(i_adc_code);
    end
    if (i_reg_reset) begin
      next_status = `CFS_STATUS_RESET;
      next_armed = 8'h00;
      next_adc = `CFS_ADC_RESET;
    end
    next_conv_off = next_status[`CFS_BIT_SYS_OV] | next_status[`CFS_BIT_SYS_UV] | ~cmp_n;
    next_rdata = o_reg_rdata;
    if (i_reg_rd) begin
      if (i_reg_addr == `CFS_ADDR_ADC_LO) begin
        next_rdata = adc[7:0];
      end else if (i_reg_addr == `CFS_ADDR_ADC_HI) begin
        next_rdata = adc[15:8];
      end else if (is_status(i_reg_addr)) begin
        next_rdata = status;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_sync <= '1;
      cmp_n <= 1'b1;
      status <= `CFS_STATUS_RESET;
      armed <= 8'h00;
      adc <= `CFS_ADC_RESET;
      o_reg_rdata <= 8'h00;
      o_converter_off <= 1'b0;
    end else if (i_clk_en) begin
      cmp_sync <= next_cmp_sync;
      cmp_n <= next_cmp_n;
      status <= next_status;
      armed <= next_armed;
      adc <= next_adc;
      o_reg_rdata <= next_rdata;
      o_converter_off <= next_conv_off;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_pin_low;
    (!i_comparator_input_pin_n && i_clk_en && !i_reg_reset) [*6];
  endsequence
  sequence s_rd_lo;
    i_clk_en && i_reg_rd && i_reg_addr == `CFS_ADDR_ADC_LO;
  endsequence
  sequence s_rd_hi;
    i_clk_en && i_reg_rd && i_reg_addr == `CFS_ADDR_ADC_HI;
  endsequence
  sequence s_rd_ov_held;
    i_clk_en && rd_status && !i_reg_reset && status[`CFS_BIT_IN_OV] &&
      i_input_overvoltage_fault;
  endsequence
  sequence s_ov_gone;
    i_clk_en && !i_reg_reset && !i_input_overvoltage_fault;
  endsequence
  sequence s_quiet_edge;
    i_clk_en && !i_reg_reset;
  endsequence

  AST_CLAMP: assert property (i_clk_en && i_adc_valid && !i_reg_reset &&
    i_adc_code > ADC_W'(`CFS_ADC_MAX) |=> adc == `CFS_ADC_MAX)
    else $error("reading not clamped");
  AST_READ_LO: assert property (s_rd_lo |=> o_reg_rdata == $past(adc[7:0]))
    else $error("low byte read wrong");
  AST_REG_RESET: assert property (i_clk_en && i_reg_reset |=> status == 8'h00 && adc == 16'h0000)
    else $error("register reset did not clear");
  AST_HOLD_ON_READ: assert property (i_clk_en && rd_status && !i_reg_reset &&
    i_input_overvoltage_fault |=> status[`CFS_BIT_IN_OV])
    else $error("bit dropped while fault present");
  AST_AUTO_CLEAR: assert property (i_clk_en && armed[`CFS_BIT_IN_OV] && !i_reg_reset &&
    !i_input_overvoltage_fault |=> !status[`CFS_BIT_IN_OV])
    else $error("armed bit did not auto-clear");
  AST_SET: assert property (i_clk_en && i_battery_discharge_overcurrent_fault &&
    !i_reg_reset |=> status[`CFS_BIT_DIS_OC] [*1])
    else $error("fault not latched");
  AST_OFF_WHILE_SET: assert property (status[`CFS_BIT_SYS_OV] || status[`CFS_BIT_SYS_UV]
    |-> o_converter_off)
    else $error("converter on with ov or uv set");
  AST_UV_STICKY: assert property (i_clk_en && status[`CFS_BIT_SYS_UV] && !i_reg_reset &&
    i_adapter_present && !(wr_status && !i_reg_wdata[`CFS_BIT_SYS_UV]) |=> status[`CFS_BIT_SYS_UV])
    else $error("undervoltage bit lost");
  AST_WRITE_CLEAR: assert property (i_clk_en && wr_status && !i_reg_wdata[`CFS_BIT_SYS_OV] &&
    !i_system_overvoltage && !i_reg_reset |=> !status[`CFS_BIT_SYS_OV])
    else $error("write zero did not clear bit 4");
  AST_UNPLUG_CLEAR: assert property (i_clk_en && !i_adapter_present && !i_system_undervoltage
    |=> !status[`CFS_BIT_SYS_UV])
    else $error("unplug did not clear bit 3");
  AST_COMPARATOR: assert property (s_pin_low |=> o_converter_off && status[`CFS_BIT_FORCED_OFF])
    else $error("comparator trigger not acted on");
  AST_RO_WRITE: assert property (i_clk_en && wr_status && i_reg_wdata[`CFS_BIT_IN_OV] &&
    !status[`CFS_BIT_IN_OV] && !i_input_overvoltage_fault && !i_reg_reset |=> !status[`CFS_BIT_IN_OV])
    else $error("write changed read-only bit");
  AST_STATUS_ADDR: assert property (i_clk_en && rd_status |=> o_reg_rdata == $past(status))
    else $error("status read wrong");
  AST_READ_HI: assert property (s_rd_hi |=> o_reg_rdata == $past(adc[15:8]))
    else $error("high byte read wrong");
  AST_READ_THEN_CLEAR: assert property (s_rd_ov_held ##1 s_ov_gone |=>
    !status[`CFS_BIT_IN_OV])
    else $error("bit not cleared after read and fault gone");
  AST_RDATA_HOLD: assert property (i_clk_en && !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  AST_FREEZE: assert property (!i_clk_en |=> $stable(status) && $stable(adc) &&
    $stable(armed) && $stable(o_converter_off) && $stable(o_reg_rdata))
    else $error("state moved while clock enable low");
  AST_CONV_ON: assert property (s_quiet_edge ##1
    !status[`CFS_BIT_SYS_OV] && !status[`CFS_BIT_SYS_UV] && !status[`CFS_BIT_FORCED_OFF]
    |-> !o_converter_off)
    else $error("converter held off with no cause");
  AST_UNMAPPED: assert property (i_clk_en && i_reg_rd && i_reg_addr != `CFS_ADDR_ADC_LO &&
    i_reg_addr != `CFS_ADDR_ADC_HI && !is_status(i_reg_addr) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ---- tb/cfs_host.sv ----
// host register access model for the fault status bank
`timescale 1ns/100ps
module cfs_host (
  input wire logic i_sys_clk,
  input wire cfs_pkg::cfs_byte_t i_rdata,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output cfs_pkg::cfs_byte_t o_wdata
);
  import cfs_pkg::*;
  initial begin
    o_addr = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output cfs_byte_t d);
    @(negedge i_sys_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_sys_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input cfs_byte_t d);
    @(negedge i_sys_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_sys_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
endmodule

// ---- tb/charger_fault_status_and_cmpin_adc_tb.sv ----
// bench for the fault status bank
`timescale 1ns/100ps
module charger_fault_status_and_cmpin_adc_tb;
  import cfs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rr = 1'b0, av = 1'b0, ov = 1'b0, uv = 1'b0, en = 1'b1;
  logic pin_n = 1'b1, ad = 1'b1, rd, wr, off;
  logic [4:0] flt = 5'h00;
  logic [15:0] code = 16'h0000;
  logic [7:0] addr;
  cfs_byte_t wd, rdata;
  logic [15:0] cv [4] = '{16'h1234, 16'h1FFF, 16'h2000, 16'hFFFF};
  logic [15:0] ce [4] = '{16'h1234, 16'h1FFF, 16'h1FFF, 16'h1FFF};
  cfs_byte_t sv [2] = '{8'h10, 8'h08};
  cfs_byte_t wv [2] = '{8'hEF, 8'hF7};
  cfs_byte_t fv [5] = '{8'h01, 8'h02, 8'h20, 8'h40, 8'h80};
  int bad_count = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  cfs_host i_host (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr),
    .o_wdata(wd));
  cfs_fault_status i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(en), .i_reg_reset(rr),
    .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_adc_code(code), .i_adc_valid(av), .i_input_overvoltage_fault(flt[4]),
    .i_battery_discharge_overcurrent_fault(flt[3]), .i_input_overcurrent_fault(flt[2]),
    .i_system_overvoltage(ov), .i_system_undervoltage(uv),
    .i_reverse_output_overvoltage_fault(flt[1]), .i_reverse_output_undervoltage_fault(flt[0]),
    .i_comparator_input_pin_n(pin_n), .i_adapter_present(ad), .o_converter_off(off));
  task automatic chk(string n, cfs_byte_t s, cfs_byte_t e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(logic [7:0] a, cfs_byte_t e);
    cfs_byte_t d;
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
  initial begin
    cyc(6);
    rst_n = 1'b1;
    rchk(8'h20, 8'h00);
    rchk(8'h1E, 8'h00);
    rchk(8'h1F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      code = cv[i];
      av = 1'b1;
      cyc(1);
      av = 1'b0;
      rchk(8'h1E, ce[i][7:0]);
      rchk(8'h1F, ce[i][15:8]);
    end
    rchk(8'h55, 8'h00);
    en = 1'b0;
    code = 16'h0123;
    av = 1'b1;
    cyc(2);
    av = 1'b0;
    en = 1'b1;
    rchk(8'h1E, 8'hFF);
    rchk(8'h1F, 8'h1F);
    flt = 5'h1F;
    cyc(2);
    rchk(8'h20, 8'hE3);
    rchk(8'h20, 8'hE3);
    flt = 5'h00;
    cyc(2);
    rchk(8'h20, 8'h00);
    flt = 5'h1F;
    cyc(1);
    flt = 5'h00;
    cyc(2);
    i_host.wr(8'h20, 8'h00);
    rchk(8'h20, 8'hE3);
    rchk(8'h20, 8'h00);
    for (int i = 0; i < 5; i++) begin
      flt = 5'h01 << i;
      cyc(1);
      flt = 5'h00;
      rchk(8'h20, fv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      ov = (i[0] == 1'b0);
      uv = (i[0] == 1'b1);
      cyc(1);
      ov = 1'b0;
      uv = 1'b0;
      cyc(1);
      chk("off", {7'h00, off}, 8'h01);
      rchk(8'h20, sv[i[0]]);
      i_host.wr(8'h20, 8'hFF);
      rchk(8'h20, sv[i[0]]);
      if (i[1] == 1'b0) begin
        i_host.wr(8'h20, wv[i[0]]);
      end else begin
        ad = 1'b0;
        cyc(1);
        ad = 1'b1;
      end
      chk("off", {7'h00, off}, 8'h00);
      rchk(8'h20, 8'h00);
    end
    pin_n = 1'b0;
    cyc(6);
    chk("off", {7'h00, off}, 8'h01);
    pin_n = 1'b1;
    cyc(6);
    chk("off", {7'h00, off}, 8'h00);
    rchk(8'h20, 8'h04);
    rchk(8'h20, 8'h00);
    pin_n = 1'b0;
    cyc(6);
    rchk(8'h20, 8'h04);
    pin_n = 1'b1;
    cyc(6);
    rchk(8'h20, 8'h00);
    flt = 5'h1F;
    cyc(1);
    flt = 5'h00;
    rr = 1'b1;
    cyc(1);
    rr = 1'b0;
    rchk(8'h20, 8'h00);
    rchk(8'h1E, 8'h00);
    rchk(8'h1F, 8'h00);
    code = 16'h0ABC;
    av = 1'b1;
    ov = 1'b1;
    flt = 5'h1F;
    cyc(2);
    av = 1'b0;
    ov = 1'b0;
    flt = 5'h00;
    chk("off", {7'h00, off}, 8'h01);
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    chk("off", {7'h00, off}, 8'h00);
    chk("rdata", rdata, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h1E, 8'h00);
    rchk(8'h1F, 8'h00);
    test_done();
  end
endmodule
